// ---- pipe_slot_pkg.sv ----
// Purpose: Shared types and constants for the pipeline slot controller.
// Assumes: One slot per clk_sys cycle; schedules shift toward bit 0.
// Notes:   Schedule masks are loaded one slot after decode, so a stage
//          at decode+k sits in mask bit k-1.
package pipe_slot_pkg;

    ////////////////////////////////////////////////////////////////////
    // Instruction classes seen at the decode stage
    typedef enum logic [3:0] {
        CLS_PLAIN,
        CLS_MEM_LOGIC,
        CLS_MEM_TEST,
        CLS_TEST_SET,
        CLS_SHIFT,
        CLS_SHIFT_FLAG,
        CLS_FLAG_SET,
        CLS_SYS_MOVE,
        CLS_BR_COND,
        CLS_BR_COND_DLY,
        CLS_JUMP,
        CLS_CALL
    } cls_t;

    ////////////////////////////////////////////////////////////////////
    // Schedule width and stage masks
    localparam int         SCH_W         = 6;
    localparam logic [5:0] SCH_NONE      = 6'h00;
    localparam logic [5:0] ACC_TWICE     = 6'h0A;   // Decode+2 and +4
    localparam logic [5:0] ACC_TRIPLE    = 6'h0E;   // Decode+2, +3, +4
    localparam logic [5:0] WRITE_LATE    = 6'h10;   // Decode+5
    localparam logic [5:0] WRITE_EARLY   = 6'h04;   // Decode+3
    localparam logic [5:0] REDIRECT_SLOT = 6'h02;   // Slot after execute

    ////////////////////////////////////////////////////////////////////
    // Decode holds and discard counts, in slots
    localparam logic [1:0] HOLD_NONE      = 2'h0;
    localparam logic [1:0] HOLD_MEM_LOGIC = 2'h2;
    localparam logic [1:0] HOLD_TSET_DSP  = 2'h3;
    localparam logic [1:0] HOLD_SYS_DSP   = 2'h2;
    localparam logic [1:0] HOLD_JUMP      = 2'h1;
    localparam logic [1:0] SQ_NONE        = 2'h0;
    localparam logic [1:0] SQ_TAKEN       = 2'h2;
    localparam logic [1:0] SQ_AFTER_SLOT  = 2'h1;

    ////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic       RST_READY = 1'b1;
    localparam logic [1:0] RST_HOLD  = 2'h0;

endpackage

// ---- pipe_slot_ctl.sv ----
// Purpose: Slot sequencing, decode stalls, discards and shared memory
//          port arbitration for a five-stage integer pipeline.
// Assumes: Decoder presents one classified instruction per slot; all
//          inputs come from logic on clk_sys.
// Notes:   Data access always wins the port; fetch waits out every data slot.
`timescale 1ns/1ps

module pipe_slot_ctl
    import pipe_slot_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    // Configuration
    input  wire logic dsp_mode,
    // Decode offer
    input  wire logic dec_valid,
    input  cls_t      dec_class,
    input  wire logic dec_reads_status,
    input  wire logic dec_rpt_ctl,
    input  wire logic dec_br_on_true,
    input  wire logic cond_flag,
    // Fetch request
    input  wire logic fetch_req,
    // Slot outputs
    output logic      dec_ready_r,
    output logic      status_busy_r,
    output logic      discard_r,
    output logic      data_sel_r,
    output logic      fetch_grant_r,
    output logic      reg_wb_r,
    output logic      flag_wb_r,
    output logic      redirect_r
);

    ////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic             rdy;
        logic [1:0]       hold;
        logic [SCH_W-1:0] msch;
        logic [SCH_W-1:0] wsch;
        logic [SCH_W-1:0] fsch;
        logic [SCH_W-1:0] rsch;
        logic [1:0]       sqc;
        logic             sqs;
        logic             srb;
        logic             disc;
        logic             fg;
    } st_t;

    st_t  st_r;
    st_t  st_nxt;
    logic kill;
    logic fire;
    logic taken;

    ////////////////////////////////////////////////////////////////////
    // Decode decisions
    // condition resolved at decode
    assign taken = (cond_flag == dec_br_on_true);
    assign kill  = dec_valid && st_r.rdy && (st_r.sqc != SQ_NONE) && !st_r.sqs;
    assign fire  = dec_valid && st_r.rdy && !kill
                   && !(dec_reads_status && st_r.srb);

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [1:0]       h;
        logic [SCH_W-1:0] m;
        logic [SCH_W-1:0] w;
        logic [SCH_W-1:0] f;
        logic [SCH_W-1:0] r;
        logic [1:0]       q;
        logic             qs;
        logic             load_sq;
        h       = HOLD_NONE;
        m       = SCH_NONE;
        w       = SCH_NONE;
        f       = SCH_NONE;
        r       = SCH_NONE;
        q       = SQ_NONE;
        qs      = 1'b0;
        load_sq = 1'b0;
        unique case (dec_class)
            CLS_PLAIN: begin
                h = HOLD_NONE;
            end
            CLS_MEM_LOGIC: begin
                m = ACC_TWICE;
                h = HOLD_MEM_LOGIC;
            end
            CLS_MEM_TEST: begin
                m = ACC_TWICE;
                f = WRITE_LATE;
            end
            CLS_TEST_SET: begin
                m = ACC_TRIPLE;
                f = WRITE_LATE;
                h = dsp_mode ? HOLD_TSET_DSP : HOLD_NONE;
            end
            CLS_SHIFT: begin
                w = WRITE_EARLY;
            end
            CLS_SHIFT_FLAG: begin
                w = WRITE_EARLY;
                f = WRITE_EARLY;
            end
            CLS_FLAG_SET: begin
                f = WRITE_EARLY;
            end
            CLS_SYS_MOVE: begin
                w = WRITE_EARLY;
                h = (dsp_mode && dec_rpt_ctl) ? HOLD_SYS_DSP : HOLD_NONE;
            end
            CLS_BR_COND: begin
                if (taken) begin
                    r       = REDIRECT_SLOT;
                    q       = SQ_TAKEN;
                    load_sq = 1'b1;
                end
            end
            CLS_BR_COND_DLY: begin
                if (taken) begin
                    // keep delay slot, drop the next
                    r       = REDIRECT_SLOT;
                    q       = SQ_AFTER_SLOT;
                    qs      = 1'b1;
                    load_sq = 1'b1;
                end
            end
            CLS_JUMP: begin
                // delay slot decode waits one slot
                r = REDIRECT_SLOT;
                h = HOLD_JUMP;
            end
            CLS_CALL: begin
                // link write, drop after delay slot
                r       = REDIRECT_SLOT;
                w       = WRITE_EARLY;
                q       = SQ_AFTER_SLOT;
                qs      = 1'b1;
                load_sq = 1'b1;
            end
        endcase

        st_nxt = st_r;
        // Schedules advance one slot every cycle
        st_nxt.msch = st_r.msch >> 1;
        st_nxt.wsch = st_r.wsch >> 1;
        st_nxt.fsch = st_r.fsch >> 1;
        st_nxt.rsch = st_r.rsch >> 1;
        st_nxt.disc = kill;

        // Hold countdown; only a fresh decode reloads it
        if (!st_r.rdy) begin
            if (st_r.hold == HOLD_NONE) begin
                st_nxt.rdy = 1'b1;
            end else begin
                st_nxt.hold = st_r.hold - 2'h1;
            end
        end

        // Discard bookkeeping for branch shadows
        if (kill) begin
            st_nxt.sqc = st_r.sqc - 2'h1;
        end
        if (fire && st_r.sqs) begin
            st_nxt.sqs = 1'b0;
        end

        if (fire) begin
            st_nxt.msch = (st_r.msch >> 1) | m;
            st_nxt.wsch = (st_r.wsch >> 1) | w;
            st_nxt.fsch = (st_r.fsch >> 1) | f;
            st_nxt.rsch = (st_r.rsch >> 1) | r;
            if (h != HOLD_NONE) begin
                st_nxt.rdy  = 1'b0;
                st_nxt.hold = h - 2'h1;
            end
            if (load_sq) begin
                st_nxt.sqc = q;
                st_nxt.sqs = qs;
            end
        end

        // busy until the status write slot has passed
        st_nxt.srb = |st_nxt.fsch;

        // data first, fetch postponed while a data slot holds the port
        st_nxt.fg = fetch_req && !st_nxt.msch[0];
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_r      <= '0;
            st_r.rdy  <= RST_READY;
            st_r.hold <= RST_HOLD;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs straight from state bits
    assign dec_ready_r   = st_r.rdy;
    assign status_busy_r = st_r.srb;
    assign discard_r     = st_r.disc;
    assign data_sel_r    = st_r.msch[0];
    assign fetch_grant_r = st_r.fg;
    assign reg_wb_r      = st_r.wsch[0];
    assign flag_wb_r     = st_r.fsch[0];
    assign redirect_r    = st_r.rsch[0];

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_two_access;
        ##2 data_sel_r ##2 data_sel_r;
    endsequence

    sequence s_three_access;
        ##2 data_sel_r [*3];
    endsequence

    a_port_one_owner: assert property (
        @(posedge clk_sys) disable iff (srst)
        !(data_sel_r && fetch_grant_r))
        else $error("fetch and data own the port together");

    a_fetch_yields: assert property (
        @(posedge clk_sys) disable iff (srst)
        fetch_req |=> fetch_grant_r || data_sel_r)
        else $error("pending fetch neither granted nor yielding to data");

    a_memlogic_slots: assert property (
        @(posedge clk_sys) disable iff (srst)
        fire && dec_class == CLS_MEM_LOGIC |-> s_two_access
            and (##1 !dec_ready_r [*2] ##1 dec_ready_r))
        else $error("memory logic slots or hold wrong");

    a_test_flag_wb: assert property (
        @(posedge clk_sys) disable iff (srst)
        fire && dec_class == CLS_MEM_TEST |-> s_two_access ##1 flag_wb_r)
        else $error("byte test access or flag write late");

    a_tset_sequence: assert property (
        @(posedge clk_sys) disable iff (srst)
        fire && dec_class == CLS_TEST_SET |-> s_three_access ##1 flag_wb_r)
        else $error("test-and-set sequence wrong");

    a_tset_dsp_hold: assert property (
        @(posedge clk_sys) disable iff (srst)
        fire && dsp_mode && dec_class == CLS_TEST_SET
            |=> !dec_ready_r [*3] ##1 dec_ready_r)
        else $error("variant hold after test-and-set wrong");

    a_status_stall: assert property (
        @(posedge clk_sys) disable iff (srst)
        fire && dec_class inside {CLS_MEM_TEST, CLS_FLAG_SET}
            |=> status_busy_r [*2])
        else $error("status update not guarded");

    a_shift_wb: assert property (
        @(posedge clk_sys) disable iff (srst)
        fire && dec_class == CLS_SHIFT |-> ##3 reg_wb_r)
        else $error("shift writeback not at decode plus three");

    a_taken_redirect: assert property (
        @(posedge clk_sys) disable iff (srst)
        fire && dec_class == CLS_BR_COND && taken
            |-> ##2 redirect_r)
        else $error("taken branch redirect late");

    a_untaken_quiet: assert property (
        @(posedge clk_sys) disable iff (srst)
        fire && dec_class == CLS_BR_COND && !taken && !st_r.rsch[1]
            |=> !redirect_r ##1 !redirect_r)
        else $error("untaken branch redirected");

    a_jump_hold: assert property (
        @(posedge clk_sys) disable iff (srst)
        fire && dec_class == CLS_JUMP
            |=> !dec_ready_r ##1 (dec_ready_r && redirect_r))
        else $error("jump delay slot timing wrong");

    a_test_port_fight: assert property (
        @(posedge clk_sys) disable iff (srst)
        fire && dec_class == CLS_MEM_TEST
            |-> ##2 !fetch_grant_r ##2 !fetch_grant_r)
        else $error("fetch granted in a byte test access slot");

    a_delayed_redirect: assert property (
        @(posedge clk_sys) disable iff (srst)
        fire && dec_class == CLS_BR_COND_DLY && taken
            |-> ##2 redirect_r)
        else $error("taken delayed branch redirect late");

    a_call_slots: assert property (
        @(posedge clk_sys) disable iff (srst)
        fire && dec_class == CLS_CALL
            |-> ##2 redirect_r ##1 reg_wb_r)
        else $error("call redirect or link write wrong");

    a_sysmove_wb: assert property (
        @(posedge clk_sys) disable iff (srst)
        fire && dec_class == CLS_SYS_MOVE |-> ##3 reg_wb_r)
        else $error("system move writeback not at decode plus three");

    a_rpt_load_hold: assert property (
        @(posedge clk_sys) disable iff (srst)
        fire && dsp_mode && dec_rpt_ctl && dec_class == CLS_SYS_MOVE
            |=> !dec_ready_r [*2] ##1 dec_ready_r)
        else $error("variant hold after repeat load wrong");

    a_flag_set_wb: assert property (
        @(posedge clk_sys) disable iff (srst)
        fire && dec_class == CLS_FLAG_SET |-> ##3 flag_wb_r)
        else $error("flag set or clear write not at decode plus three");

endmodule

// ---- fetch_unit_model.sv ----
// Purpose: Fetch unit on the far side of the shared memory port.
// Assumes: Grant shows one slot after the request that it serves.
// Notes:   Keeps asking until served, as a prefetcher would.
`timescale 1ns/1ps

module fetch_unit_model (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    // Port handshake
    input  wire logic fetch_grant_r,
    output logic      fetch_req
);
    ////////////////////////////////////////////////////////////////////
    // held until served
    always @(negedge clk_sys) begin
        if (srst) begin
            fetch_req <= 1'b0;
        end else if (!fetch_req || fetch_grant_r) begin
            fetch_req <= ($urandom % 4) != 0;  // Mostly busy, to force port fights
        end
    end
endmodule

// ---- testbench.sv ----
// Purpose: Self-checking bench for the pipeline slot controller.
// Assumes: One offer per slot, driven on the falling edge.
// Notes:   A ring of 16 slots holds the pulses the model expects.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin err_total++; \
    $display("ERROR %s expected %0b seen %0b", nm, e, a); end end

module testbench
    import pipe_slot_pkg::*;
;
    logic       clk_sys, srst, dsp_mode, dec_valid, dec_reads_status, dec_rpt_ctl;
    logic       dec_br_on_true, cond_flag, fetch_req, req_q, rst_q, chk_on, mode_sel;
    cls_t       dec_class;
    logic       dec_ready_r, status_busy_r, discard_r, data_sel_r, fetch_grant_r;
    logic       reg_wb_r, flag_wb_r, redirect_r;
    logic [4:0] ev [16];
    int         err_total, check_count, cyc, h, disc, dly, lb, pend, want_rst;
    logic [31:0] sched [12] = '{32'h0, 32'h14, 32'h200014, 32'h20001C, 32'h800,
        32'h80800, 32'h80000, 32'h800, 32'h4000000, 32'h4000000, 32'h4000000, 32'h4000800};

    pipe_slot_ctl u_pipe_slot_ctl (.clk_sys, .srst, .dsp_mode, .dec_valid, .dec_class,
        .dec_reads_status, .dec_rpt_ctl, .dec_br_on_true, .cond_flag, .fetch_req,
        .dec_ready_r, .status_busy_r, .discard_r, .data_sel_r, .fetch_grant_r, .reg_wb_r,
        .flag_wb_r, .redirect_r);
    fetch_unit_model u_fetch_unit_model (.clk_sys, .srst, .fetch_grant_r, .fetch_req);

    ////////////////////////////////////////////////////////////////////
    // Clock, previous-slot samples and a hang limit
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        req_q <= fetch_req;
        rst_q <= srst;
        cyc <= cyc + 1;
        if (cyc > 3000) begin
            err_total++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Model of an accepted offer; branches are kept out of shadows
    task automatic take();
        logic [31:0] s;
        s = sched[dec_class];
        // delay slot runs, next one dropped
        if (dly) begin
            dly = 0;
            disc = 1;
        end
        if (dec_class inside {CLS_BR_COND, CLS_BR_COND_DLY} && cond_flag != dec_br_on_true)
            s = 32'h0;
        if (s != 0 && dec_class == CLS_BR_COND) disc = 2;
        if (s != 0 && dec_class inside {CLS_BR_COND_DLY, CLS_CALL}) dly = 1;
        lb = dec_class >= CLS_BR_COND;
        for (int k = 0; k < 8; k++)
            for (int f = 0; f < 4; f++)
                if (s[8 * f + k]) ev[(cyc + k) % 16][f] = 1'b1;
        h = (dec_class == CLS_MEM_LOGIC || (dsp_mode && dec_rpt_ctl &&
            dec_class == CLS_SYS_MOVE)) ? 2 : (dsp_mode && dec_class == CLS_TEST_SET) ? 3 :
            (dec_class == CLS_JUMP) ? 1 : 0;
    endtask

    ////////////////////////////////////////////////////////////////////
    // One slot: compare settled outputs, then present and judge an offer
    task automatic slot();
        logic [4:0] e;
        logic       busy;
        logic       rdy;
        @(negedge clk_sys);
        e = ev[cyc % 16];
        busy = 1'b0;
        for (int i = 0; i < 6; i++) busy |= ev[(cyc + i) % 16][2];
        rdy = (h == 0);
        if (h > 0) h--;
        if (chk_on) begin
            `CHK("ready", rdy, dec_ready_r)
            `CHK("status busy", busy, status_busy_r)
            `CHK("data slot", e[0], data_sel_r)
            `CHK("reg writeback", e[1], reg_wb_r)
            `CHK("flag writeback", e[2], flag_wb_r)
            `CHK("redirect", e[3], redirect_r)
            `CHK("discard", e[4], discard_r)
            `CHK("fetch grant", req_q & ~e[0] & ~rst_q, fetch_grant_r)
        end
        ev[cyc % 16] = 5'h00;
        if (want_rst > 0) begin
            want_rst--;
            srst = 1'b1;
            dec_valid = 1'b0;
            {h, disc, dly, lb, pend} = '0;
            foreach (ev[i]) ev[i] = 5'h00;
        end else begin
            srst = 1'b0;
            // Mode is set every slot before the offer, so model and design see the same mode
            dsp_mode = mode_sel;
            // Refused offers stay up unchanged
            if (!pend) begin
                dec_valid = ($urandom % 8) != 0;
                dec_class = (disc > 0 || dly || lb) ? CLS_PLAIN : cls_t'($urandom % 12);
                {dec_reads_status, dec_rpt_ctl, dec_br_on_true, cond_flag} = 4'($urandom);
            end
            pend = 0;
            if (dec_valid && rdy && disc > 0) begin
                disc--;
                ev[(cyc + 1) % 16][4] = 1'b1;
            end else if (dec_valid && rdy && !(dec_reads_status && busy)) begin
                take();
            end else begin
                pend = dec_valid;
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    // Verdict
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Plain mode, signal-processing mode, then a reset in mid-run
    initial begin
        {clk_sys, srst, dsp_mode, dec_valid, chk_on} = 5'h00;
        {dec_reads_status, dec_rpt_ctl, dec_br_on_true, cond_flag} = 4'h0;
        dec_class = CLS_PLAIN;
        void'($urandom(32'h83D6D7EA));
        want_rst = 8;
        repeat (8) slot();
        chk_on = 1'b1;
        for (int p = 0; p < 3; p++) begin
            mode_sel = (p != 0);
            if (p == 2) want_rst = 2;
            repeat (400) slot();
            $display("Test %0d done: checks %0d, errors %0d", p, check_count, err_total);
        end
        conclude();
    end
endmodule
